//--- core/power_mode_wake_pkg.sv
/*
 Constants and types shared by the power mode and wake controller
 and its retention register store.
 Assumes a 20 MHz always-on core clock.
*/
package power_mode_wake_pkg;

   ////////////////////////////////////////////////////////////////////
   // Power modes
   typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP, MODE_DEEP} mode_t;

   ////////////////////////////////////////////////////////////////////
   // Supply domain bit positions
   localparam int DOM_N       = 14;
   localparam int D_MCU       = 0;
   localparam int D_NORM_RAM  = 1;  // Normal, exchange, cache, CAN RAM
   localparam int D_FLASH     = 2;
   localparam int D_PERIPH    = 3;
   localparam int D_IO_CTRL   = 4;
   localparam int D_SENSOR    = 5;
   localparam int D_RADIO     = 6;
   localparam int D_HF_CLK    = 7;  // Fast crystal and fast RC
   localparam int D_RET_RAM   = 8;
   localparam int D_LP_TIMER  = 9;
   localparam int D_XTAL_32K  = 10;
   localparam int D_RET_REG   = 11;
   localparam int D_WAKE_RF   = 12;
   localparam int D_LF_RC     = 13;

   // Domain masks per mode
   localparam logic [DOM_N-1:0] ACTIVE_MASK = 14'h3fff;
   localparam logic [DOM_N-1:0] SLEEP_MASK  = 14'h3f00;
   localparam logic [DOM_N-1:0] DEEP_MASK   = 14'h3800;

   ////////////////////////////////////////////////////////////////////
   // Retention registers: 128 bytes as 32 words
   localparam int RET_BYTES = 128;
   localparam int RET_DW    = 32;
   localparam int RET_AW    = 5;

   // Wake timers
   localparam int RTC_N = 4;
   localparam int RTC_W = 16;

   // Oscillator selections and reset values
   localparam logic [1:0] LF_SEL_1K   = 2'h0;
   localparam logic [1:0] LF_SEL_4K   = 2'h1;
   localparam logic [1:0] LF_SEL_32K  = 2'h2;
   localparam logic [1:0] LF_SEL_64K  = 2'h3;
   localparam logic [1:0] HF_SEL_2M   = 2'h0;
   localparam logic [1:0] HF_SEL_4M   = 2'h1;
   localparam logic [1:0] HF_SEL_16M  = 2'h2;
   localparam logic [1:0] LF_SEL_RST  = LF_SEL_32K;
   localparam logic [1:0] HF_SEL_RST  = HF_SEL_16M;

   ////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS    = 50;
   localparam int SUPPLY_SETTLE_NS = 20000;
   localparam int HF_START_NS      = 6800;
   localparam int SUPPLY_SETTLE_CYC =
      (SUPPLY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HF_START_CYC =
      (HF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_W = 12;

endpackage : power_mode_wake_pkg

//--- core/ret_reg_store.sv
/*
 Retention register store: words with a registered read port and a
 one-cycle clear of all contents.
 Assumes it sits in the always-on domain on the core clock.
*/
`timescale 1ns/1ns
module ret_reg_store
   import power_mode_wake_pkg::*;
#(
   parameter int AW = RET_AW,
   parameter int DW = RET_DW
) (
   input  wire logic          core_clk,
   input  wire logic          nrst,
   input  wire logic          clk_en,
   input  wire logic          clear,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);

   typedef struct packed {
      logic [(2**AW)-1:0][DW-1:0] words;
      logic [DW-1:0]              rdata;
   } store_t;

   store_t st;
   store_t next_st;

   ////////////////////////////////////////////////////////////////////
   // Write, clear and registered read
   always_comb begin
      next_st = st;
      if (clear) begin
         next_st.words = '0;
         next_st.rdata = '0;
      end else begin
         if (wr_en) begin
            next_st.words[addr] = wdata;
         end
         next_st.rdata = st.words[addr];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;

endmodule : ret_reg_store

//--- core/power_mode_wake_controller.sv
/*
 Power mode and wake controller: sequences supplies, clocks, resets
 and pad retention between Active, Sleep and Deep Sleep.
 Assumes core_clk is always on and that request inputs come from
 logic on core_clk; pad inputs are asynchronous.
*/
// Overview of operation
// (RL1) Exactly one of Active, Sleep, Deep Sleep is selected.
// (RL2) Active mode keeps every supply domain switched on.
// (RL3) Sleep powers only radio-link keeping domains; others off.
// (RL4) Deep Sleep powers only periodic wake logic and always-on domain.
// (RL5) Mode changes switch the DC-DC converter and LDO enables.
// (RL6) Clocks, resets and pad retention are coordinated with mode.
// (RL7) 128 bytes of retention registers stay powered in all modes.
// (RL8) Retention RAM powered in Sleep, off in Deep Sleep.
// (RL9) Retained modules only hold data outside Active mode.
// (RL10) Both low modes power down processor, memories, radio, fast clocks.
// (RL11) Radio low-power timer wakes from Sleep; unpowered in Deep Sleep.
// (RL12) Slow crystal runs in Active and Sleep, off in Deep Sleep.
// (RL13) Wake receiver powered always; its wake accepted in Sleep.
// (RL14) Four timers wake from either low mode or act as watchdog.
// (RL15) Watchdog expiry gives interrupt or chip reset as configured.
// (RL16) Watchdog timers keep counting in every mode.
// (RL17) Reset pad resets chip to Active and loses retained data.
// (RL18) Slow RC selectable 1/4/32/64 kHz, always running.
// (RL19) Fast RC selectable 2/4/16 MHz.
// (RL20) Wake pads wake both modes; supplies, clocks restored first.
`timescale 1ns/1ns
module power_mode_wake_controller
   import power_mode_wake_pkg::*;
#(
   parameter int SETTLE_CYC = SUPPLY_SETTLE_CYC,
   parameter int CLK_START_CYC = HF_START_CYC
) (
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire logic                   clk_en,
   input  wire logic                   reset_pad_n,
   input  wire logic [3:0]             wake_pad,
   input  wire logic                   sleep_req,
   input  wire logic                   deep_sel,
   input  wire logic                   lp_timer_wake,
   input  wire logic                   wake_rf_hit,
   input  wire logic [RTC_N-1:0]       rtc_en,
   input  wire logic [RTC_N-1:0]       rtc_wdog,
   input  wire logic [RTC_N-1:0]       rtc_wdog_rst,
   input  wire logic [RTC_N-1:0]       rtc_kick,
   input  wire logic [RTC_N*RTC_W-1:0] rtc_period,
   input  wire logic [1:0]             lf_sel_in,
   input  wire logic [1:0]             hf_sel_in,
   input  wire logic                   ret_wr,
   input  wire logic [RET_AW-1:0]      ret_addr,
   input  wire logic [RET_DW-1:0]      ret_wdata,
   output logic      [RET_DW-1:0]      ret_rdata,
   output mode_t                       power_mode,
   output logic      [DOM_N-1:0]       ldo_en,
   output logic                        dcdc_en,
   output logic                        clk_run,
   output logic                        core_rst_n,
   output logic                        chip_rst_n,
   output logic                        pad_retain,
   output logic      [RTC_N-1:0]       rtc_irq,
   output logic      [RTC_N-1:0]       rtc_wake,
   output logic      [1:0]             lf_sel,
   output logic      [1:0]             hf_sel
);

   typedef enum logic [2:0] {
      S_ACTIVE, S_FREEZE, S_PWR_DOWN, S_LOW, S_PWR_UP, S_CLK_UP,
      S_RELEASE
   } seq_t;

   typedef struct packed {
      seq_t                        seq;
      mode_t                       mode;
      mode_t                       target;
      logic [WAIT_W-1:0]           wait_cnt;
      logic                        wake_pend;
      logic [1:0]                  rst_sync;
      logic [3:0]                  wk_s1;
      logic [3:0]                  wk_s2;
      logic [3:0]                  wk_prev;
      logic [RTC_N-1:0][RTC_W-1:0] rtc_cnt;
      logic [RTC_N-1:0]            rtc_irq;
      logic [RTC_N-1:0]            rtc_wake;
      logic [DOM_N-1:0]            dom_en;
      logic                        dcdc_en;
      logic                        clk_run;
      logic                        core_rst_n;
      logic                        chip_rst_n;
      logic                        pad_retain;
      logic [1:0]                  lf_sel;
      logic [1:0]                  hf_sel;
   } state_t;

   localparam state_t RESET_ST = '{
      seq: S_ACTIVE, mode: MODE_ACTIVE, target: MODE_ACTIVE,
      wait_cnt: '0, wake_pend: 1'b0, rst_sync: 2'h3,
      wk_s1: '0, wk_s2: '0, wk_prev: '0, rtc_cnt: '0,
      rtc_irq: '0, rtc_wake: '0, dom_en: ACTIVE_MASK,
      dcdc_en: 1'b1, clk_run: 1'b1, core_rst_n: 1'b1,
      chip_rst_n: 1'b1, pad_retain: 1'b0,
      lf_sel: LF_SEL_RST, hf_sel: HF_SEL_RST};

   localparam logic [WAIT_W-1:0] SETTLE_LAST =
      WAIT_W'(SETTLE_CYC - 1);
   localparam logic [WAIT_W-1:0] CLK_LAST =
      WAIT_W'(CLK_START_CYC - 1);

   state_t st;
   state_t next_st;

   ////////////////////////////////////////////////////////////////////
   // Wake sources accepted in a given low mode
   function automatic logic wake_hit(
      input mode_t      m,
      input logic       rtc_any,
      input logic       pad_any,
      input logic       lpt,
      input logic       rf
   );
      logic hit;
      hit = 1'b0;
      case (m)
         MODE_SLEEP: hit = rtc_any | pad_any | lpt | rf; // RL11 RL13
         MODE_DEEP:  hit = rtc_any | pad_any;            // RL14 RL20
         default:    hit = 1'b0;
      endcase
      return hit;
   endfunction : wake_hit

   ////////////////////////////////////////////////////////////////////
   // Timer expiry, pad edges and chip reset causes
   logic [RTC_N-1:0] rtc_expire;
   logic [RTC_N-1:0] rtc_event;
   logic [3:0]       pad_rise;
   logic             wdog_reset;
   logic             pad_reset;
   logic             wake_now;
   logic             ret_write_ok;

   always_comb begin
      for (int i = 0; i < RTC_N; i++) begin
         rtc_expire[i] = rtc_en[i] &&
            (st.rtc_cnt[i] == rtc_period[i*RTC_W +: RTC_W]);
      end
      rtc_event  = rtc_expire & ~rtc_wdog;                  // RL14
      wdog_reset = |(rtc_expire & rtc_wdog & rtc_wdog_rst); // RL15
      pad_rise   = st.wk_s2 & ~st.wk_prev;
      pad_reset  = !st.rst_sync[1];                         // RL17
      wake_now   = st.wake_pend ||
         wake_hit(st.target, |rtc_event, |pad_rise,
                  lp_timer_wake, wake_rf_hit);
      ret_write_ok = ret_wr && (st.seq == S_ACTIVE);        // RL9
   end

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_st = st;
      // Pad synchronisers
      next_st.rst_sync = {st.rst_sync[0], reset_pad_n};
      next_st.wk_s1    = wake_pad;
      next_st.wk_s2    = st.wk_s1;
      next_st.wk_prev  = st.wk_s2;
      next_st.lf_sel   = lf_sel_in;                         // RL18
      if (hf_sel_in != 2'h3) begin
         next_st.hf_sel = hf_sel_in;                        // RL19
      end
      // Timers count in every mode, reload on expiry or kick
      for (int i = 0; i < RTC_N; i++) begin
         if (!rtc_en[i] || rtc_kick[i] || rtc_expire[i]) begin
            next_st.rtc_cnt[i] = '0;                        // RL16
         end else begin
            next_st.rtc_cnt[i] = st.rtc_cnt[i] + RTC_W'(1); // RL16
         end
      end
      next_st.rtc_irq  =
         rtc_expire & rtc_wdog & ~rtc_wdog_rst;             // RL15
      next_st.rtc_wake = '0;
      if (st.wait_cnt != '0) begin
         next_st.wait_cnt = st.wait_cnt - WAIT_W'(1);
      end
      // Mode sequence
      case (st.seq)
         S_ACTIVE: begin
            next_st.wake_pend = 1'b0;
            if (sleep_req) begin
               next_st.target = deep_sel ? MODE_DEEP : MODE_SLEEP;
               // Stop clocks, hold core, freeze pads
               next_st.clk_run    = 1'b0;                   // RL6
               next_st.core_rst_n = 1'b0;                   // RL6
               next_st.pad_retain = 1'b1;                   // RL6
               next_st.seq        = S_FREEZE;
            end
         end
         S_FREEZE: begin
            next_st.mode = st.target;                       // RL1
            if (st.target == MODE_DEEP) begin
               next_st.dom_en = DEEP_MASK;        // RL4 RL8 RL11 RL12
            end else begin
               next_st.dom_en = SLEEP_MASK;       // RL3 RL8 RL10 RL12
            end
            next_st.dcdc_en  = 1'b0;                        // RL5
            next_st.wait_cnt = SETTLE_LAST;
            next_st.seq      = S_PWR_DOWN;
         end
         S_PWR_DOWN: begin
            next_st.wake_pend = wake_now;
            if (st.wait_cnt == '0) begin
               next_st.seq = S_LOW;
            end
         end
         S_LOW: begin
            if (wake_now) begin
               next_st.rtc_wake = rtc_event;                // RL14
               next_st.dom_en   = ACTIVE_MASK;              // RL2 RL20
               next_st.dcdc_en  = 1'b1;                     // RL5
               next_st.wait_cnt = SETTLE_LAST;
               next_st.seq      = S_PWR_UP;
            end
         end
         S_PWR_UP: begin
            if (st.wait_cnt == '0) begin
               next_st.mode     = MODE_ACTIVE;              // RL1
               next_st.clk_run  = 1'b1;                     // RL20
               next_st.wait_cnt = CLK_LAST;
               next_st.seq      = S_CLK_UP;
            end
         end
         S_CLK_UP: begin
            if (st.wait_cnt == '0) begin
               next_st.seq = S_RELEASE;
            end
         end
         S_RELEASE: begin
            next_st.core_rst_n = 1'b1;                      // RL20
            next_st.pad_retain = 1'b0;                      // RL6
            next_st.target     = MODE_ACTIVE;
            next_st.seq        = S_ACTIVE;
         end
         default: begin
            next_st.seq = S_ACTIVE;
         end
      endcase
      // Chip reset overrides the sequence, synchronisers kept
      next_st.chip_rst_n = !(pad_reset || wdog_reset);      // RL15 RL17
      if (pad_reset || wdog_reset) begin
         next_st.seq        = S_ACTIVE;                     // RL17
         next_st.mode       = MODE_ACTIVE;
         next_st.target     = MODE_ACTIVE;
         next_st.dom_en     = ACTIVE_MASK;
         next_st.dcdc_en    = 1'b1;
         next_st.clk_run    = 1'b1;
         next_st.core_rst_n = 1'b1;
         next_st.pad_retain = 1'b0;
         next_st.wake_pend  = 1'b0;
         next_st.wait_cnt   = '0;
         next_st.rtc_cnt    = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st <= RESET_ST;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Retention registers, cleared on chip reset
   ret_reg_store #(
      .AW (RET_AW),
      .DW (RET_DW)
   ) u_ret_store (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .clear    (pad_reset || wdog_reset),                  // RL17
      .wr_en    (ret_write_ok),                             // RL7 RL9
      .addr     (ret_addr),
      .wdata    (ret_wdata),
      .rdata    (ret_rdata)
   );

   // Outputs straight from state
   assign power_mode = st.mode;
   assign ldo_en     = st.dom_en;
   assign dcdc_en    = st.dcdc_en;
   assign clk_run    = st.clk_run;
   assign core_rst_n = st.core_rst_n;
   assign chip_rst_n = st.chip_rst_n;
   assign pad_retain = st.pad_retain;
   assign rtc_irq    = st.rtc_irq;
   assign rtc_wake   = st.rtc_wake;
   assign lf_sel     = st.lf_sel;
   assign hf_sel     = st.hf_sel;

   ////////////////////////////////////////////////////////////////////
   // Checks
   property p_one_mode;
      @(posedge core_clk) disable iff (!nrst)
      st.mode inside {MODE_ACTIVE, MODE_SLEEP, MODE_DEEP};
   endproperty
   a_one_mode: assert property (p_one_mode) // RL1
      else $error("invalid power mode");

   property p_active_all;
      @(posedge core_clk) disable iff (!nrst)
      (st.seq == S_ACTIVE) |-> (ldo_en == ACTIVE_MASK && dcdc_en);
   endproperty
   a_active_all: assert property (p_active_all) // RL2
      else $error("domain off in active mode");

   property p_sleep_mask;
      @(posedge core_clk) disable iff (!nrst)
      (st.seq == S_LOW && st.mode == MODE_SLEEP) |->
         (ldo_en == SLEEP_MASK && !ldo_en[D_MCU] && ldo_en[D_LP_TIMER]);
   endproperty
   a_sleep_mask: assert property (p_sleep_mask) // RL3
      else $error("wrong domains in sleep");

   property p_deep_mask;
      @(posedge core_clk) disable iff (!nrst)
      (st.seq == S_LOW && st.mode == MODE_DEEP) |->
         (ldo_en == DEEP_MASK && !ldo_en[D_RET_RAM]
          && !ldo_en[D_XTAL_32K]);
   endproperty
   a_deep_mask: assert property (p_deep_mask) // RL4
      else $error("wrong domains in deep sleep");

   property p_always_on;
      @(posedge core_clk) disable iff (!nrst)
      ldo_en[D_RET_REG] && ldo_en[D_WAKE_RF] && ldo_en[D_LF_RC];
   endproperty
   a_always_on: assert property (p_always_on) // RL7
      else $error("always-on domain switched off");

   sequence s_enter;
      st.seq == S_ACTIVE && sleep_req && clk_en && !pad_reset
         && !wdog_reset;
   endsequence
   sequence s_frozen;
      !clk_run && !core_rst_n && pad_retain ##1 (!dcdc_en || !chip_rst_n);
   endsequence
   property p_enter;
      @(posedge core_clk) disable iff (!nrst)
      s_enter |=> s_frozen;
   endproperty
   a_enter: assert property (p_enter) // RL6
      else $error("entry order of clocks, pads, supply wrong");

   property p_release;
      @(posedge core_clk) disable iff (!nrst)
      ($rose(core_rst_n) && chip_rst_n) |->
         ($past(clk_run) && ldo_en == ACTIVE_MASK && !pad_retain);
   endproperty
   a_release: assert property (p_release) // RL20
      else $error("core released before supplies and clocks");

   property p_wdog;
      @(posedge core_clk) disable iff (!nrst)
      (clk_en && |(rtc_expire & rtc_wdog & rtc_wdog_rst)) |=>
         (!chip_rst_n ##1 power_mode == MODE_ACTIVE);
   endproperty
   a_wdog: assert property (p_wdog) // RL15
      else $error("watchdog reset not taken");

   property p_pad_reset;
      @(posedge core_clk) disable iff (!nrst)
      (clk_en && pad_reset) |=>
         (!chip_rst_n && power_mode == MODE_ACTIVE && ret_rdata == '0);
   endproperty
   a_pad_reset: assert property (p_pad_reset) // RL17
      else $error("reset pad did not reset chip");

   property p_deep_no_lpt;
      @(posedge core_clk) disable iff (!nrst)
      (clk_en && st.seq == S_LOW && st.target == MODE_DEEP && !st.wake_pend
       && !(|rtc_event) && !(|pad_rise) && !pad_reset && !wdog_reset)
         |=> (st.seq == S_LOW);
   endproperty
   a_deep_no_lpt: assert property (p_deep_no_lpt) // RL11
      else $error("deep sleep woken by unsupported source");

endmodule : power_mode_wake_controller

//--- bench/wake_source_model.sv
/*
 Behavioural model of the wake pads and the reset pad.
 Assumes the bench asks for pad activity on core_clk.
*/
`timescale 1ns/1ns
module wake_source_model (
   input  wire logic       core_clk,
   input  wire logic [3:0] pad_hit,
   input  wire logic       rst_hold,
   output logic      [3:0] wake_pad,
   output logic            reset_pad_n
);
   logic [2:0] cnt;

   // Idle pads low, reset pad released
   initial begin
      wake_pad = 4'h0;
      reset_pad_n = 1'b1;
      cnt = 3'h0;
   end

   // Pads held long enough to pass the synchronisers
   always @(posedge core_clk) begin
      reset_pad_n <= !rst_hold;
      if (pad_hit != 4'h0) begin
         wake_pad <= pad_hit;
         cnt <= 3'h6;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
      end else begin
         wake_pad <= 4'h0;
      end
   end
endmodule : wake_source_model

//--- bench/power_mode_wake_controller_bench.sv
/*
 Self-checking bench for the power mode and wake controller.
 Assumes shortened settle and clock start counts of 4 and 3.
*/
`timescale 1ns/1ns
module power_mode_wake_controller_bench
   import power_mode_wake_pkg::*;
;
   logic core_clk, nrst, sleep_req, deep_sel, lp_timer_wake, wake_rf_hit;
   logic ret_wr, rst_hold, seen_ok;
   logic [3:0] pad_hit, wake_pad, rtc_en, rtc_wdog, rtc_wdog_rst, rtc_irq;
   logic [3:0] rtc_wake, seen_wake, seen_irq;
   logic [RTC_N*RTC_W-1:0] rtc_period;
   logic [1:0] lf_sel_in, hf_sel_in, lf_sel, hf_sel;
   logic [RET_AW-1:0] ret_addr;
   logic [RET_DW-1:0] ret_wdata, ret_rdata;
   logic [DOM_N-1:0] ldo_en;
   logic reset_pad_n, dcdc_en, clk_run, core_rst_n, chip_rst_n, pad_retain;
   mode_t power_mode;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;

   wake_source_model u_wake_source_model (.core_clk(core_clk),
      .pad_hit(pad_hit), .rst_hold(rst_hold), .wake_pad(wake_pad),
      .reset_pad_n(reset_pad_n));

   power_mode_wake_controller #(.SETTLE_CYC(4), .CLK_START_CYC(3))
   u_power_mode_wake_controller (.core_clk(core_clk), .nrst(nrst),
      .clk_en(1'b1), .reset_pad_n(reset_pad_n), .wake_pad(wake_pad),
      .sleep_req(sleep_req), .deep_sel(deep_sel),
      .lp_timer_wake(lp_timer_wake), .wake_rf_hit(wake_rf_hit),
      .rtc_en(rtc_en), .rtc_wdog(rtc_wdog), .rtc_wdog_rst(rtc_wdog_rst),
      .rtc_kick(4'h0), .rtc_period(rtc_period), .lf_sel_in(lf_sel_in),
      .hf_sel_in(hf_sel_in), .ret_wr(ret_wr), .ret_addr(ret_addr),
      .ret_wdata(ret_wdata), .ret_rdata(ret_rdata),
      .power_mode(power_mode), .ldo_en(ldo_en), .dcdc_en(dcdc_en),
      .clk_run(clk_run), .core_rst_n(core_rst_n), .chip_rst_n(chip_rst_n),
      .pad_retain(pad_retain), .rtc_irq(rtc_irq), .rtc_wake(rtc_wake),
      .lf_sel(lf_sel), .hf_sel(hf_sel));

   ////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #25 core_clk = !core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   // Request a low mode and let supplies settle
   task automatic enter(input logic deep);
      @(posedge core_clk);
      sleep_req <= 1'b1;
      deep_sel <= deep;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      tick(8);
   endtask : enter

   // Bounded wait for the processor release, noting pulses
   task automatic wake_wait(input int lim);
      seen_ok = 1'b0;
      seen_wake = 4'h0;
      seen_irq = 4'h0;
      for (int i = 0; i < lim && !seen_ok; i++) begin
         tick(1);
         seen_wake = seen_wake | rtc_wake;
         seen_irq = seen_irq | rtc_irq;
         seen_ok = (core_rst_n === 1'b1) && (power_mode === MODE_ACTIVE);
      end
   endtask : wake_wait

   task automatic low_state(input mode_t m, input logic [DOM_N-1:0] mask);
      chk(32'(power_mode), 32'(m));
      chk(32'(ldo_en), 32'(mask));
      chk({dcdc_en, clk_run, core_rst_n, pad_retain}, 4'h1);
   endtask : low_state

   task automatic conclude();
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_osc();
      for (int i = 0; i < 4; i++) begin
         lf_sel_in <= 2'(i);
         tick(2);
         chk(32'(lf_sel), i);
      end
      for (int i = 0; i < 4; i++) begin
         hf_sel_in <= 2'(i);
         tick(2);
         chk(32'(hf_sel), (i == 3) ? 2 : i);
      end
   endtask : t_osc

   // Sleep, watchdog interrupt without wake, receiver wake
   task automatic t_sleep();
      enter(1'b0);
      low_state(MODE_SLEEP, SLEEP_MASK);
      chk(32'(ldo_en[D_LP_TIMER] & ldo_en[D_XTAL_32K]), 1);
      rtc_wdog <= 4'h2;
      rtc_period[31:16] <= 16'h0008;
      rtc_en <= 4'h2;
      wake_wait(30);
      chk(32'(seen_irq), 32'h2);
      chk(32'(power_mode), 32'(MODE_SLEEP));
      rtc_en <= 4'h0;
      wake_rf_hit <= 1'b1;
      wake_wait(40);
      wake_rf_hit <= 1'b0;
      chk(32'(seen_ok), 1);
      chk(32'(ldo_en), 32'(ACTIVE_MASK));
   endtask : t_sleep

   // Deep Sleep ignores timer and receiver, keeps words, pad wakes
   task automatic t_deep();
      ret_addr <= 5'h1f;
      ret_wdata <= 32'ha5c3_0f1e;
      ret_wr <= 1'b1;
      tick(1);
      ret_wr <= 1'b0;
      enter(1'b1);
      low_state(MODE_DEEP, DEEP_MASK);
      ret_wdata <= 32'h0;
      ret_wr <= 1'b1;
      lp_timer_wake <= 1'b1;
      wake_rf_hit <= 1'b1;
      wake_wait(20);
      chk(32'(seen_ok), 0);
      ret_wr <= 1'b0;
      lp_timer_wake <= 1'b0;
      wake_rf_hit <= 1'b0;
      pad_hit <= 4'h4;
      tick(1);
      pad_hit <= 4'h0;
      wake_wait(40);
      chk(32'(seen_ok), 1);
      tick(2);
      chk(ret_rdata, 32'ha5c3_0f1e);
   endtask : t_deep

   // Timer wake from Deep Sleep, then watchdog chip reset
   task automatic t_rtc();
      rtc_wdog <= 4'h0;
      rtc_period[15:0] <= 16'h0014;
      rtc_en <= 4'h1;
      enter(1'b1);
      wake_wait(60);
      chk(32'(seen_wake), 32'h1);
      rtc_wdog <= 4'h8;
      rtc_wdog_rst <= 4'h8;
      rtc_period[63:48] <= 16'h0006;
      rtc_en <= 4'h8;
      seen_ok = 1'b0;
      for (int i = 0; i < 20 && !seen_ok; i++) begin
         tick(1);
         seen_ok = (chip_rst_n === 1'b0);
      end
      rtc_en <= 4'h0;
      chk(32'(seen_ok), 1);
   endtask : t_rtc

   // Reset pad in Sleep clears store and returns to Active
   task automatic t_pad_rst();
      ret_wdata <= 32'h1234_5678;
      ret_wr <= 1'b1;
      tick(1);
      ret_wr <= 1'b0;
      enter(1'b0);
      rst_hold <= 1'b1;
      tick(8);
      chk(32'(chip_rst_n), 0);
      rst_hold <= 1'b0;
      tick(8);
      chk(32'(power_mode), 32'(MODE_ACTIVE));
      chk(ret_rdata, 32'h0);
   endtask : t_pad_rst

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {core_clk, nrst, sleep_req, deep_sel} = 4'h0;
      {lp_timer_wake, wake_rf_hit} = 2'h0;
      {ret_wr, rst_hold, pad_hit, rtc_en, rtc_wdog, rtc_wdog_rst} = 18'h0;
      rtc_period = '0;
      lf_sel_in = LF_SEL_RST;
      hf_sel_in = HF_SEL_RST;
      ret_addr = 5'h0;
      ret_wdata = 32'h0;
      tick(20);
      nrst <= 1'b1;
      tick(1);
      chk(32'(ldo_en), 32'(ACTIVE_MASK));
      chk({dcdc_en, clk_run, core_rst_n, pad_retain}, 4'he);
      t_osc();
      t_sleep();
      t_deep();
      t_rtc();
      t_pad_rst();
      conclude();
   end
endmodule : power_mode_wake_controller_bench
